// *** hdl/tosc_top.sv ***
// One-shot timer output, start trigger, interrupt flag and pin direction control
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tosc_top #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pulse pin, port 3 bit 1
    input wire logic p31_in,
    output logic p31_out,
    output logic p31_oe,
    // Interrupts
    output logic ch0_count_end_irq,
    output logic irq
);

    // Reload registers are 16 bits, so a wider counter could never be loaded
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
        $error("tosc_top: CNT_W out of range");
    end

    // ==========================================================
    // Bus decode
    logic wr_en;
    logic rd_en;
    logic [31:0] wd;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign wd = pwdata;
    // Zero wait states: every register answers in its first access cycle
    assign pready = 1'b1;

    logic addr_ok;
    always_comb begin
        case (paddr)
            tosc_pkg::OFF_OUT_ENABLE, tosc_pkg::OFF_OUT_LEVEL, tosc_pkg::OFF_START_TRIG,
            tosc_pkg::OFF_ENABLE_STAT, tosc_pkg::OFF_PORT3_DIR, tosc_pkg::OFF_IRQ_FLAGS,
            tosc_pkg::OFF_IRQ_MASK, tosc_pkg::OFF_DELAY, tosc_pkg::OFF_WIDTH,
            tosc_pkg::OFF_EVT_STATUS, tosc_pkg::OFF_EVT_CLEAR,
            tosc_pkg::OFF_EVT_ENABLE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    // ==========================================================
    // Configuration registers
    logic [15:0] out_enable_ff;
    logic [7:0] port3_dir_ff;
    logic [7:0] irq_mask_ff;
    logic [15:0] delay_ff;
    logic [15:0] width_ff;
    localparam int EVT_WIDTH = tosc_pkg::EVT_W;
    logic [EVT_WIDTH-1:0] evt_enable_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_enable_ff <= tosc_pkg::RST_OUT_ENABLE;
            port3_dir_ff <= tosc_pkg::RST_PORT3_DIR;
            irq_mask_ff <= tosc_pkg::RST_IRQ_MASK;
            delay_ff <= tosc_pkg::RST_DELAY;
            width_ff <= tosc_pkg::RST_WIDTH;
            evt_enable_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                tosc_pkg::OFF_OUT_ENABLE: out_enable_ff <= wd[15:0] & tosc_pkg::CH_USED_MASK;
                tosc_pkg::OFF_PORT3_DIR: port3_dir_ff <= wd[7:0];
                tosc_pkg::OFF_IRQ_MASK: irq_mask_ff <= wd[7:0];
                tosc_pkg::OFF_DELAY: delay_ff <= wd[15:0];
                tosc_pkg::OFF_WIDTH: width_ff <= wd[15:0];
                tosc_pkg::OFF_EVT_ENABLE: evt_enable_ff <= wd[EVT_WIDTH-1:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Start triggers and channels
    logic trig_wr;
    logic ch0_trig;
    logic ch3_trig;
    tosc_pkg::tosc_ch_cfg_t cfg0;
    tosc_pkg::tosc_ch_cfg_t cfg3;
    tosc_pkg::tosc_ch_stat_t st0;
    tosc_pkg::tosc_ch_stat_t st3;

    // Trigger bits are strobes that nothing stores, so the register reads zero
    assign trig_wr = wr_en && (paddr == tosc_pkg::OFF_START_TRIG);
    // Ch0 trigger on a written 1
    assign ch0_trig = trig_wr && wd[tosc_pkg::CH0_BIT];
    // Ch3 trigger on a written 1
    assign ch3_trig = trig_wr && wd[tosc_pkg::CH3_BIT];

    // Delay on ch0, width on ch3
    assign cfg0.reload = delay_ff;
    assign cfg0.start = ch0_trig;
    assign cfg0.start_on_event = 1'b0;
    assign cfg3.reload = width_ff;
    assign cfg3.start = ch3_trig;
    assign cfg3.start_on_event = 1'b1;

    tosc_channel #(.CNT_W(CNT_W)) u_ch0 (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg0),
        .ext_start(1'b0),
        .stat(st0)
    );

    // Ch3 started by ch0 count end
    tosc_channel #(.CNT_W(CNT_W)) u_ch3 (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg3),
        .ext_start(st0.count_end),
        .stat(st3)
    );

    assign ch0_count_end_irq = st0.count_end;

    // ==========================================================
    // Output levels
    logic [15:0] out_level_ff;
    logic lvl_wr;
    logic ch3_go;

    assign lvl_wr = wr_en && (paddr == tosc_pkg::OFF_OUT_LEVEL);
    // Only an armed, idle ch3 takes the ch0 end, so an end in mid-pulse is dropped
    assign ch3_go = st0.count_end && st3.enabled && !st3.running;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_level_ff <= tosc_pkg::RST_OUT_LEVEL;
        end else begin
            if (out_enable_ff[tosc_pkg::CH3_BIT]) begin
                if (ch3_go) begin
                    out_level_ff[tosc_pkg::CH3_BIT] <= 1'b1;
                end else if (st3.count_end) begin
                    out_level_ff[tosc_pkg::CH3_BIT] <= 1'b0;
                end
            end else if (lvl_wr) begin
                out_level_ff[tosc_pkg::CH3_BIT] <= wd[tosc_pkg::CH3_BIT];
            end
            // Writes ignored while enabled (branch above)
            // Ch0 follows the same scheme, toggling at its count end
            if (out_enable_ff[tosc_pkg::CH0_BIT]) begin
                if (st0.count_end) begin
                    out_level_ff[tosc_pkg::CH0_BIT] <= !out_level_ff[tosc_pkg::CH0_BIT];
                end
            end else if (lvl_wr) begin
                out_level_ff[tosc_pkg::CH0_BIT] <= wd[tosc_pkg::CH0_BIT];
            end
        end
    end

    // ==========================================================
    // Pin driver
    // Direction 0 turns the buffer on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p31_out <= 1'b0;
            p31_oe <= 1'b0;
        end else begin
            p31_out <= out_level_ff[tosc_pkg::CH3_BIT];
            p31_oe <= !port3_dir_ff[tosc_pkg::P3B1_BIT];
        end
    end

    // ==========================================================
    // Interrupt request flags and event status
    logic [7:0] irq_flags_ff;
    logic [EVT_WIDTH-1:0] evt_status_ff;
    logic [EVT_WIDTH-1:0] evt_in;
    logic flg_wr;
    logic clr_wr;

    assign flg_wr = wr_en && (paddr == tosc_pkg::OFF_IRQ_FLAGS);
    assign clr_wr = wr_en && (paddr == tosc_pkg::OFF_EVT_CLEAR);
    assign evt_in[tosc_pkg::EVT_CH0_END] = st0.count_end;
    assign evt_in[tosc_pkg::EVT_CH3_END] = st3.count_end;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_flags_ff <= tosc_pkg::RST_IRQ_FLAGS;
        end else begin
            if (flg_wr) begin
                irq_flags_ff <= wd[7:0];
            end
            // Request sets flag; set beats clear
            if (st0.count_end) begin
                irq_flags_ff[tosc_pkg::IRQ_CH0_BIT] <= 1'b1;
            end
        end
    end

    logic [EVT_WIDTH-1:0] evt_clr;
    logic [EVT_WIDTH-1:0] nxt_evt_status;

    // An event and its clear in one cycle: the set wins so no event is lost
    always_comb begin
        evt_clr = clr_wr ? wd[EVT_WIDTH-1:0] : '0;
        nxt_evt_status = (evt_status_ff & ~evt_clr) | evt_in;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_status_ff <= '0;
        end else begin
            evt_status_ff <= nxt_evt_status;
        end
    end

    // Mask 0 lets the ch0 request through
    assign irq = (|(evt_status_ff & evt_enable_ff)) ||
                 (irq_flags_ff[tosc_pkg::IRQ_CH0_BIT] && !irq_mask_ff[tosc_pkg::IRQ_CH0_BIT]);

    // ==========================================================
    // Read data
    logic [15:0] en_stat;
    always_comb begin
        en_stat = '0;
        en_stat[tosc_pkg::CH0_BIT] = st0.enabled;
        en_stat[tosc_pkg::CH3_BIT] = st3.enabled;
    end

    logic [7:0] dir_rd;
    always_comb begin
        dir_rd = port3_dir_ff;
        dir_rd[0] = port3_dir_ff[0] ? p31_in : port3_dir_ff[0];
        dir_rd[0] = port3_dir_ff[0];
    end

    logic [31:0] nxt_prdata;
    always_comb begin
        case (paddr)
            tosc_pkg::OFF_OUT_ENABLE: nxt_prdata = {16'h0000, out_enable_ff};
            tosc_pkg::OFF_OUT_LEVEL: nxt_prdata = {16'h0000, out_level_ff};
            tosc_pkg::OFF_START_TRIG: nxt_prdata = 32'h0000_0000;
            tosc_pkg::OFF_ENABLE_STAT: nxt_prdata = {16'h0000, en_stat};
            tosc_pkg::OFF_PORT3_DIR: nxt_prdata = {24'h000000, dir_rd};
            tosc_pkg::OFF_IRQ_FLAGS: nxt_prdata = {24'h000000, irq_flags_ff};
            tosc_pkg::OFF_IRQ_MASK: nxt_prdata = {24'h000000, irq_mask_ff};
            tosc_pkg::OFF_DELAY: nxt_prdata = {16'h0000, delay_ff};
            tosc_pkg::OFF_WIDTH: nxt_prdata = {16'h0000, width_ff};
            tosc_pkg::OFF_EVT_STATUS: nxt_prdata = 32'(evt_status_ff);
            tosc_pkg::OFF_EVT_ENABLE: nxt_prdata = 32'(evt_enable_ff);
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Captured in the setup cycle so the word stands for the whole access phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= nxt_prdata;
        end
    end

    logic unused_ok;
    assign unused_ok = rd_en & p31_in & st0.running;

endmodule
`default_nettype wire

// *** hdl/tosc_pkg.sv ***
// Package for the one-shot timer output and start control block
package tosc_pkg;

    // ==========================================================
    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_OUT_ENABLE = 8'h00;
    localparam logic [7:0] OFF_OUT_LEVEL = 8'h04;
    localparam logic [7:0] OFF_START_TRIG = 8'h08;
    localparam logic [7:0] OFF_ENABLE_STAT = 8'h0C;
    localparam logic [7:0] OFF_PORT3_DIR = 8'h10;
    localparam logic [7:0] OFF_IRQ_FLAGS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_DELAY = 8'h1C;
    localparam logic [7:0] OFF_WIDTH = 8'h20;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
    localparam logic [7:0] OFF_EVT_CLEAR = 8'h28;
    localparam logic [7:0] OFF_EVT_ENABLE = 8'h2C;

    // ==========================================================
    // Field positions
    localparam int CH0_BIT = 0;
    localparam int CH3_BIT = 3;
    localparam int P3B1_BIT = 1;
    localparam int IRQ_CH0_BIT = 4;
    localparam int EVT_CH0_END = 0;
    localparam int EVT_CH3_END = 1;
    localparam int EVT_W = 2;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_OUT_ENABLE = 16'h0000;
    localparam logic [15:0] RST_OUT_LEVEL = 16'h0000;
    localparam logic [7:0] RST_PORT3_DIR = 8'hFF;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_WIDTH = 16'h0000;

    // Bits of the output register and the trigger register that exist
    localparam logic [15:0] CH_USED_MASK = 16'h0009;

    // Counter phase of one channel
    typedef enum logic [1:0] {
        TOSC_IDLE,
        TOSC_ARMED,
        TOSC_COUNT
    } tosc_phase_t;

    // Configuration handed to one channel counter
    typedef struct packed {
        logic [15:0] reload;
        logic start;
        logic start_on_event;
    } tosc_ch_cfg_t;

    // Status returned by one channel counter
    typedef struct packed {
        logic enabled;
        logic running;
        logic count_end;
    } tosc_ch_stat_t;

endpackage

// *** hdl/tosc_channel.sv ***
// One one-count channel: arm on a start trigger, count down, pulse at the end
`timescale 1ns/1ps
`default_nettype none
module tosc_channel #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire tosc_pkg::tosc_ch_cfg_t cfg,
    input wire logic ext_start,
    // Status
    output tosc_pkg::tosc_ch_stat_t stat
);

    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
        $error("tosc_channel: CNT_W out of range");
    end

    // ==========================================================
    // Enable status and counter
    tosc_pkg::tosc_phase_t phase_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic end_ff;
    logic go;

    assign go = cfg.start_on_event ? ext_start : 1'b1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_ff <= tosc_pkg::TOSC_IDLE;
            cnt_ff <= '0;
            end_ff <= 1'b0;
        end else begin
            end_ff <= 1'b0;
            case (phase_ff)
                tosc_pkg::TOSC_IDLE: begin
                    if (cfg.start) begin
                        phase_ff <= tosc_pkg::TOSC_ARMED;
                    end
                end
                tosc_pkg::TOSC_ARMED: begin
                    if (go) begin
                        phase_ff <= tosc_pkg::TOSC_COUNT;
                        cnt_ff <= cfg.reload[CNT_W-1:0];
                    end
                end
                tosc_pkg::TOSC_COUNT: begin
                    if (cnt_ff == '0) begin
                        end_ff <= 1'b1;
                        phase_ff <= cfg.start_on_event ? tosc_pkg::TOSC_ARMED
                                                       : tosc_pkg::TOSC_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    phase_ff <= tosc_pkg::TOSC_IDLE;
                end
            endcase
        end
    end

    assign stat.enabled = (phase_ff != tosc_pkg::TOSC_IDLE);
    assign stat.running = (phase_ff == tosc_pkg::TOSC_COUNT);
    assign stat.count_end = end_ff;

endmodule
`default_nettype wire

// *** bench/tosc_top_asserts.sv ***
// Port checker for the one-shot timer control block
`timescale 1ns/1ps
`default_nettype none
module tosc_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin and interrupts
    input wire logic p31_in,
    input wire logic p31_out,
    input wire logic p31_oe,
    input wire logic ch0_count_end_irq,
    input wire logic irq
);
    // ==========================================
    // Write decode and ch3 output enable shadow
    logic wr_any;
    logic wr_lvl;
    logic oe3_ff;
    assign wr_any = psel && penable && pwrite;
    assign wr_lvl = wr_any && paddr == tosc_pkg::OFF_OUT_LEVEL;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe3_ff <= 1'b0;
        end else if (wr_any && paddr == tosc_pkg::OFF_OUT_ENABLE) begin
            oe3_ff <= pwdata[3];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Properties
    a_level_fixed: assert property ((!oe3_ff && !wr_lvl) [*3] |=> $stable(p31_out))
        else $error("pin level moved while output disabled");
    a_level_written: assert property (wr_lvl && !oe3_ff
        |-> ##2 p31_out == $past(pwdata[3], 2))
        else $error("pin level differs from written level");
    a_level_ignored: assert property (wr_lvl && oe3_ff && !p31_out && !ch0_count_end_irq
        |-> ##2 !p31_out)
        else $error("level write taken while output enabled");
    a_pulse_starts: assert property (ch0_count_end_irq && oe3_ff |-> ##[1:3] p31_out)
        else $error("pulse did not start after ch0 count end");
    a_pulse_cause: assert property ($rose(p31_out) && oe3_ff && $past(oe3_ff, 3)
        |-> $past(ch0_count_end_irq) || $past(ch0_count_end_irq, 2)
        || $past(ch0_count_end_irq, 3))
        else $error("pulse rose without ch0 count end");
    a_dir_to_oe: assert property (wr_any && paddr == tosc_pkg::OFF_PORT3_DIR
        |-> ##2 p31_oe == !$past(pwdata[1], 2))
        else $error("pin drive does not follow direction bit");
    a_end_single: assert property (ch0_count_end_irq |=> !ch0_count_end_irq)
        else $error("ch0 count end longer than one cycle");
    a_trig_zero: assert property (psel && penable && !pwrite
        && paddr == tosc_pkg::OFF_START_TRIG |-> prdata == 32'h0)
        else $error("trigger register read not zero");
endmodule
bind tosc_top tosc_top_asserts u_tosc_asserts (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p31_in(p31_in), .p31_out(p31_out), .p31_oe(p31_oe),
    .ch0_count_end_irq(ch0_count_end_irq), .irq(irq));
`default_nettype wire

// *** bench/tosc_pin_model.sv ***
// Far-side circuit on the pulse pin: drives the pin input and times each pulse
`timescale 1ns/1ps
`default_nettype none
module tosc_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin as seen from outside
    input wire logic p31_out,
    input wire logic p31_oe,
    output logic p31_in,
    // Last pulse width in cycles and pulse count
    output var int width,
    output var int pulses
);
    logic last_ff;
    int run_ff;
    // No pull on the pin: a released pin shows the inverse of the level last driven
    assign p31_in = p31_oe ? p31_out : !last_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_ff <= 1'b0;
            run_ff <= 0;
            width <= 0;
            pulses <= 0;
        end else begin
            if (p31_oe) begin
                last_ff <= p31_out;
            end
            if (p31_oe && p31_out) begin
                run_ff <= run_ff + 1;
            end else if (run_ff > 0) begin
                width <= run_ff;
                pulses <= pulses + 1;
                run_ff <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tosc_top_tb_top.sv ***
// Self-checking bench for the one-shot timer control block
`timescale 1ns/1ps
`default_nettype none
module tosc_top_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, v;
    logic pready, pslverr, p31_in, p31_out, p31_oe, ch0_count_end_irq, irq, rerr;
    logic [7:0] rnd = 8'h24;
    logic [31:0] mdl [int];
    int width, pulses, n, d, w;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;

    always #5 clk = !clk;

    tosc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .p31_in(p31_in), .p31_out(p31_out), .p31_oe(p31_oe),
        .ch0_count_end_irq(ch0_count_end_irq), .irq(irq));
    tosc_pin_model far (.clk(clk), .rst_n(rst_n), .p31_out(p31_out), .p31_oe(p31_oe),
        .p31_in(p31_in), .width(width), .pulses(pulses));

    // ==========================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One APB transfer; leaves the bus idle for a cycle before the next
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat);
        mdl[a] = dat;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Registered outputs settle within two edges; look mid-cycle
    task automatic nap();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_end();
        n = 0;
        while (ch0_count_end_irq !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n < 300), 32'h1);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ==========================================
    // Tests
    initial begin
        mdl[tosc_pkg::OFF_OUT_ENABLE] = 32'(tosc_pkg::RST_OUT_ENABLE);
        mdl[tosc_pkg::OFF_OUT_LEVEL] = 32'(tosc_pkg::RST_OUT_LEVEL);
        mdl[tosc_pkg::OFF_PORT3_DIR] = 32'(tosc_pkg::RST_PORT3_DIR);
        mdl[tosc_pkg::OFF_IRQ_FLAGS] = 32'(tosc_pkg::RST_IRQ_FLAGS);
        mdl[tosc_pkg::OFF_IRQ_MASK] = 32'(tosc_pkg::RST_IRQ_MASK);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (mdl[a]) rd(8'(a), mdl[a]);
        chk(32'(p31_oe), 32'h0);
        rd(tosc_pkg::OFF_START_TRIG, 32'h0);
        rd(8'h30, 32'h0);
        chk(32'(rerr), 32'h1);
        wr(tosc_pkg::OFF_PORT3_DIR, 32'hFD);
        nap();
        chk(32'(p31_oe), 32'h1);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            v = 32'(rnd) & 32'h9;
            wr(tosc_pkg::OFF_OUT_LEVEL, v);
            nap();
            chk(32'(p31_out), 32'(v[3]));
            rd(tosc_pkg::OFF_OUT_LEVEL, v);
        end
        $display("map and level test done");
        wr(tosc_pkg::OFF_DELAY, 32'h28);
        apb(1'b1, tosc_pkg::OFF_START_TRIG, 32'h6);
        rd(tosc_pkg::OFF_ENABLE_STAT, 32'h0);
        apb(1'b1, tosc_pkg::OFF_START_TRIG, 32'h8);
        rd(tosc_pkg::OFF_ENABLE_STAT, 32'h8);
        apb(1'b1, tosc_pkg::OFF_START_TRIG, 32'h1);
        rd(tosc_pkg::OFF_ENABLE_STAT, 32'h9);
        wait_end();
        nap();
        rd(tosc_pkg::OFF_ENABLE_STAT, 32'h8);
        chk(32'(p31_out), 32'(v[3]));
        rd(tosc_pkg::OFF_OUT_LEVEL, v);
        $display("trigger test done");
        rnd = lfsr(rnd);
        d = 8 + rnd[3:0];
        w = 4 + rnd[7:4];
        wr(tosc_pkg::OFF_IRQ_FLAGS, 32'h0);
        wr(tosc_pkg::OFF_IRQ_MASK, 32'hEF);
        apb(1'b1, tosc_pkg::OFF_EVT_CLEAR, 32'h3);
        wr(tosc_pkg::OFF_EVT_ENABLE, 32'h0);
        wr(tosc_pkg::OFF_DELAY, 32'(d));
        wr(tosc_pkg::OFF_WIDTH, 32'(w));
        wr(tosc_pkg::OFF_OUT_LEVEL, 32'h0);
        wr(tosc_pkg::OFF_OUT_ENABLE, 32'h9);
        apb(1'b1, tosc_pkg::OFF_OUT_LEVEL, 32'h9);
        nap();
        chk(32'(p31_out), 32'h0);
        rd(tosc_pkg::OFF_OUT_LEVEL, 32'h0);
        v = 32'(pulses);
        apb(1'b1, tosc_pkg::OFF_START_TRIG, 32'h9);
        wait_end();
        chk(32'(n >= d + 1 && n <= d + 4), 32'h1);
        n = 0;
        while (32'(pulses) == v && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n < 300), 32'h1);
        // Level rises on the ch0 end and falls on the ch3 end, both registered: w+2 cycles
        chk(32'(width), 32'(w + 2));
        nap();
        rd(tosc_pkg::OFF_IRQ_FLAGS, 32'h10);
        chk(32'(irq), 32'h1);
        wr(tosc_pkg::OFF_IRQ_MASK, 32'hFF);
        nap();
        chk(32'(irq), 32'h0);
        rd(tosc_pkg::OFF_ENABLE_STAT, 32'h8);
        rd(tosc_pkg::OFF_OUT_LEVEL, 32'h1);
        rd(tosc_pkg::OFF_EVT_STATUS, 32'h3);
        wr(tosc_pkg::OFF_EVT_ENABLE, 32'h1);
        nap();
        chk(32'(irq), 32'h1);
        apb(1'b1, tosc_pkg::OFF_EVT_CLEAR, 32'h3);
        nap();
        chk(32'(irq), 32'h0);
        rd(tosc_pkg::OFF_EVT_STATUS, 32'h0);
        $display("one-shot test done");
        end_of_test();
    end
endmodule
`default_nettype wire
